// >>> cirq_map.svh
// Register offsets, field positions and reset values of the contactless request unit.
`ifndef CIRQ_MAP_SVH
`define CIRQ_MAP_SVH

`define CIRQ_ADDR_W          6
`define CIRQ_OFS_COMM_EN     6'h02
`define CIRQ_OFS_DIV_EN      6'h03
`define CIRQ_OFS_COMM_REQ    6'h04
`define CIRQ_OFS_DIV_REQ     6'h05
`define CIRQ_OFS_STATUS      6'h07
`define CIRQ_OFS_RX_CFG      6'h0c

`define CIRQ_RST_COMM_EN     8'h80
`define CIRQ_RST_DIV_EN      8'h00
`define CIRQ_RST_COMM_REQ    7'h14
`define CIRQ_RST_DIV_REQ     5'h00
`define CIRQ_RST_RX_CFG      1'h0

`define CIRQ_BIT_POLARITY    7
`define CIRQ_BIT_INVERT      7
`define CIRQ_BIT_DRIVE_PP    7
`define CIRQ_BIT_TX          6
`define CIRQ_BIT_RX          5
`define CIRQ_BIT_IDLE        4
`define CIRQ_BIT_HI          3
`define CIRQ_BIT_LO          2
`define CIRQ_BIT_ERR         1
`define CIRQ_BIT_TIMER       0
`define CIRQ_BIT_SIG         4
`define CIRQ_BIT_MODE        3
`define CIRQ_BIT_CRC         2
`define CIRQ_BIT_FON         1
`define CIRQ_BIT_FOFF        0
`define CIRQ_BIT_STAT_IRQ    4
`define CIRQ_BIT_STAT_HI     1
`define CIRQ_BIT_STAT_LO     0

`define CIRQ_CMD_IDLE        4'h0
`define CIRQ_CMD_KNOWN_MASK  16'hf18f

`endif

// >>> cirq_pkg.sv
// Types shared by the contactless request unit and its users.
package cirq_pkg;

  // Detector state, one-hot.
  typedef enum logic [2:0] {
    CIRQ_DET_OFF  = 3'b001,
    CIRQ_DET_HUNT = 3'b010,
    CIRQ_DET_DONE = 3'b100
  } cirq_det_t;

  // Event and status inputs from the surrounding frontend.
  typedef struct packed {
    logic        tx_last_bit_sent;   // Pulse: last transmitted bit has left.
    logic        rx_end_valid;       // Pulse: end of a valid incoming stream.
    logic        rx_fifo_has_data;   // Level: data bytes present in the FIFO.
    logic        cmd_self_done;      // Pulse: running command ended by itself.
    logic        cmd_host_write;     // Pulse: host wrote the command field.
    logic [3:0]  cmd_host_code;      // Code written with cmd_host_write.
    logic        fifo_high_level;    // Level: live FIFO high alert.
    logic        fifo_low_level;     // Level: live FIFO low alert.
    logic [7:0]  error_status;       // Level: error status bits.
    logic [15:0] countdown_current_value; // Live timer value.
    logic        secure_link_input;  // Level: secure-link input pin.
    logic        auto_anticollision_command; // Level: that command is running.
    logic        mode_found;         // Pulse: communication mode recognised.
    logic        field_reset;        // Pulse: field reset seen.
    logic        checksum_cmd_active; // Level: checksum command running.
    logic        checksum_all_done;  // Pulse: all checksum data processed.
    logic        external_field;     // Level: external field present.
  } cirq_events_t;

  // Whole state of the unit.
  typedef struct packed {
    logic [7:0]  comm_en;        // Comm enable; bit 7 inverts the pin.
    logic [7:0]  div_en;         // Divided enable; bit 7 selects push-pull.
    logic [6:0]  comm_req;       // Latched communication request flags.
    logic [4:0]  div_req;        // Latched divided request flags.
    logic        receive_ignore_empty; // Receive-done needs FIFO data.
    logic        seen;           // Edge history below is valid.
    logic        sig_prev;       // Previous secure-link input level.
    logic        field_prev;     // Previous external field level.
    logic        timer_nonzero;  // Previous timer value was not zero.
    cirq_det_t   det;            // Data mode detector state.
    logic        irq_status;     // Combined request status.
    logic        irq_out;        // Pin output value.
    logic        irq_oe;         // Pin output enable.
    logic        cmd_force_idle; // Pulse: return command field to idle.
    logic [7:0]  rdata;          // Read data.
  } cirq_state_t;

endpackage

// >>> cirq_unit.sv
// Interrupt request flags, enables and pin driver of the contactless frontend.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "cirq_map.svh"

// Behaviour
// - Drive select one makes pin push-pull.
// - Drive select zero makes pin open-drain.
// - Enable bit 4 gates secure-input edge request.
// - Bits 3, 2 gate mode, checksum requests.
// - Bits 1, 0 gate field on, off.
// - Comm write sets or clears marked flags.
// - Divided write sets or clears marked flags.
// - Transmit-done flag set after last bit.
// - Receive-done flag set at valid end.
// - Ignore-empty needs FIFO data for receive-done.
// - Idle flag set when command ends itself.
// - Unknown command returns idle, sets flag.
// - Host starting idle leaves flag alone.
// - FIFO high level latched into bit 3.
// - FIFO low level latched into bit 2.
// - Any error status bit sets error flag.
// - Timer reaching zero sets timer flag.
// - Either secure-input edge sets its flag.
// - Mode detection sets mode-detected flag.
// - Detector runs under anticollision, restarts after reset.
// - Checksum done sets checksum flag.
// - Field appearing or vanishing sets flags.
// - Invert bit complements the pin level.
module cirq_unit
  import cirq_pkg::*;
(
  // Clock and reset.
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // Register port.
  input  wire logic [`CIRQ_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // Event sources.
  input  wire cirq_events_t             events,
  // Command control.
  output logic                          cmd_force_idle,
  output logic                          mode_detector_run,
  // Interrupt pin.
  output logic                          irq_pin_o,
  output logic                          irq_pin_oe
);

  cirq_state_t st_q;  // Registered state.
  cirq_state_t st_d;  // Next state.

  // Register selects for this cycle's write.
  logic wr_comm_en;
  logic wr_div_en;
  logic wr_comm_req;
  logic wr_div_req;
  logic wr_rx_cfg;
  logic [6:0] comm_set;   // Hardware set terms, communication flags.
  logic [4:0] div_set;    // Hardware set terms, divided flags.
  logic       level;      // Pin level before drive mode.
  logic       cmd_unknown; // Host started a code that this unit does not know.

  // One bit per command code. A clear bit marks a code that is sent back to idle.
  // A literal cannot be indexed, so the mask is held as a named constant.
  localparam logic [15:0] known_cmd_mask = `CIRQ_CMD_KNOWN_MASK;

  // An unknown code both returns the command field to idle and sets the idle flag.
  assign cmd_unknown = events.cmd_host_write && !known_cmd_mask[events.cmd_host_code];

  assign wr_comm_en  = reg_wr && (reg_addr == `CIRQ_OFS_COMM_EN);
  assign wr_div_en   = reg_wr && (reg_addr == `CIRQ_OFS_DIV_EN);
  assign wr_comm_req = reg_wr && (reg_addr == `CIRQ_OFS_COMM_REQ);
  assign wr_div_req  = reg_wr && (reg_addr == `CIRQ_OFS_DIV_REQ);
  assign wr_rx_cfg   = reg_wr && (reg_addr == `CIRQ_OFS_RX_CFG);

  // Hardware set terms; the edge terms wait until history has been sampled once,
  // so a high input at reset release does not fake an edge.
  always_comb begin
    comm_set = 7'h00;
    div_set  = 5'h00;
    comm_set[`CIRQ_BIT_TX] = events.tx_last_bit_sent;
    comm_set[`CIRQ_BIT_RX] = events.rx_end_valid &&
        (!st_q.receive_ignore_empty || events.rx_fifo_has_data);
    comm_set[`CIRQ_BIT_IDLE] = events.cmd_self_done || cmd_unknown;
    comm_set[`CIRQ_BIT_HI]    = events.fifo_high_level;
    comm_set[`CIRQ_BIT_LO]    = events.fifo_low_level;
    comm_set[`CIRQ_BIT_ERR]   = |events.error_status;
    comm_set[`CIRQ_BIT_TIMER] = st_q.seen && st_q.timer_nonzero &&
        (events.countdown_current_value == 16'h0000);
    div_set[`CIRQ_BIT_SIG] = st_q.seen &&
        (events.secure_link_input != st_q.sig_prev);
    div_set[`CIRQ_BIT_MODE] = (st_q.det == CIRQ_DET_HUNT) && events.mode_found;
    div_set[`CIRQ_BIT_CRC] = events.checksum_cmd_active && events.checksum_all_done;
    div_set[`CIRQ_BIT_FON]  = st_q.seen && events.external_field && !st_q.field_prev;
    div_set[`CIRQ_BIT_FOFF] = st_q.seen && !events.external_field && st_q.field_prev;
  end

  // Next-state logic for every register, the detector, the pin and read data.
  always_comb begin
    st_d = st_q;
    // Edge history.
    st_d.seen          = 1'b1;
    st_d.sig_prev      = events.secure_link_input;
    st_d.field_prev    = events.external_field;
    st_d.timer_nonzero = (events.countdown_current_value != 16'h0000);
    // Configuration writes.
    if (wr_comm_en) begin
      st_d.comm_en = reg_wdata;
    end
    if (wr_div_en) begin
      // Bits 6 and 5 are reserved and held at zero.
      st_d.div_en = reg_wdata & 8'h9f;
    end
    if (wr_rx_cfg) begin
      st_d.receive_ignore_empty = reg_wdata[0];
    end
    // Flag writes: polarity bit chooses set or clear of marked flags;
    // unmarked flags stay. Hardware sets are OR-ed in afterwards so an event
    // arriving with a clear is never lost.
    if (wr_comm_req) begin
      if (reg_wdata[`CIRQ_BIT_POLARITY]) begin
        st_d.comm_req = st_q.comm_req | reg_wdata[6:0];
      end else begin
        st_d.comm_req = st_q.comm_req & ~reg_wdata[6:0];
      end
    end
    if (wr_div_req) begin
      if (reg_wdata[`CIRQ_BIT_POLARITY]) begin
        st_d.div_req = st_q.div_req | reg_wdata[4:0];
      end else begin
        st_d.div_req = st_q.div_req & ~reg_wdata[4:0];
      end
    end
    st_d.comm_req = st_d.comm_req | comm_set;
    st_d.div_req  = st_d.div_req | div_set;
    // An unknown command is sent back to idle; a host idle write is not
    // a self-ending command and sets nothing.
    st_d.cmd_force_idle = cmd_unknown;
    // Data mode detector.
    unique case (st_q.det)
      CIRQ_DET_OFF: begin
        if (events.auto_anticollision_command) begin
          st_d.det = CIRQ_DET_HUNT;
        end
      end
      CIRQ_DET_HUNT: begin
        if (!events.auto_anticollision_command) begin
          st_d.det = CIRQ_DET_OFF;
        end else if (events.mode_found) begin
          st_d.det = CIRQ_DET_DONE;
        end
      end
      CIRQ_DET_DONE: begin
        if (!events.auto_anticollision_command) begin
          st_d.det = CIRQ_DET_OFF;
        end else if (events.field_reset) begin
          st_d.det = CIRQ_DET_HUNT;
        end
      end
      default: begin
        st_d.det = CIRQ_DET_OFF;
      end
    endcase
    // Pin path is built from next values so the pin flops line up with the flags.
    st_d.irq_status = (|(st_d.comm_req & st_d.comm_en[6:0])) ||
        (|(st_d.div_req & st_d.div_en[4:0]));
    level = st_d.irq_status ^ st_d.comm_en[`CIRQ_BIT_INVERT];
    if (st_d.div_en[`CIRQ_BIT_DRIVE_PP]) begin
      st_d.irq_out = level;
      st_d.irq_oe  = 1'b1;
    end else begin
      // Open drain only ever pulls low; a high level lets the pin float.
      st_d.irq_out = 1'b0;
      st_d.irq_oe  = !level;
    end
    // Read data for the next cycle only; reads change no flag.
    st_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `CIRQ_OFS_COMM_EN:  st_d.rdata = st_q.comm_en;
        `CIRQ_OFS_DIV_EN:   st_d.rdata = st_q.div_en;
        `CIRQ_OFS_COMM_REQ: st_d.rdata = {1'b0, st_q.comm_req};
        `CIRQ_OFS_DIV_REQ:  st_d.rdata = {3'b000, st_q.div_req};
        `CIRQ_OFS_STATUS: begin
          st_d.rdata[`CIRQ_BIT_STAT_IRQ] = st_q.irq_status;
          st_d.rdata[`CIRQ_BIT_STAT_HI]  = events.fifo_high_level;
          st_d.rdata[`CIRQ_BIT_STAT_LO]  = events.fifo_low_level;
        end
        `CIRQ_OFS_RX_CFG:   st_d.rdata = {7'h00, st_q.receive_ignore_empty};
        default:            st_d.rdata = 8'h00;
      endcase
    end
  end

  // State register. Reset pin level: invert one and open drain leaves it floating.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q.comm_en              <= `CIRQ_RST_COMM_EN;
      st_q.div_en               <= `CIRQ_RST_DIV_EN;
      st_q.comm_req             <= `CIRQ_RST_COMM_REQ;
      st_q.div_req              <= `CIRQ_RST_DIV_REQ;
      st_q.receive_ignore_empty <= `CIRQ_RST_RX_CFG;
      st_q.seen                 <= 1'b0;
      st_q.sig_prev             <= 1'b0;
      st_q.field_prev           <= 1'b0;
      st_q.timer_nonzero        <= 1'b0;
      st_q.det                  <= CIRQ_DET_OFF;
      st_q.irq_status           <= 1'b0;
      st_q.irq_out              <= 1'b0;
      st_q.irq_oe               <= 1'b0;
      st_q.cmd_force_idle       <= 1'b0;
      st_q.rdata                <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops.
  assign reg_rdata         = st_q.rdata;
  assign cmd_force_idle    = st_q.cmd_force_idle;
  // The hunt state is one-hot bit 1, so the output is a flop bit with no decode.
  assign mode_detector_run = st_q.det[1];
  assign irq_pin_o         = st_q.irq_out;
  assign irq_pin_oe        = st_q.irq_oe;

  // Checks on the flags and the pin.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_comm_write_set: assert property (wr_comm_req && reg_wdata[7]
      |=> (st_q.comm_req & $past(reg_wdata[6:0])) == $past(reg_wdata[6:0]))
    else $error("comm flags not set by write");
  a_comm_write_clr: assert property (wr_comm_req && !reg_wdata[7] && reg_wdata[6]
      && !events.tx_last_bit_sent |=> !st_q.comm_req[6])
    else $error("transmit flag not cleared by write");
  a_div_write_set: assert property (wr_div_req && reg_wdata[7]
      |=> (st_q.div_req & $past(reg_wdata[4:0])) == $past(reg_wdata[4:0]))
    else $error("divided flags not set by write");
  a_read_keeps: assert property (reg_rd && !reg_wr && comm_set == 7'h00
      |=> st_q.comm_req == $past(st_q.comm_req))
    else $error("read changed flags");
  a_tx_flag_set: assert property (events.tx_last_bit_sent |=> st_q.comm_req[6])
    else $error("transmit flag missed");
  a_rx_empty_gate: assert property (events.rx_end_valid && st_q.receive_ignore_empty
      && !events.rx_fifo_has_data && !reg_wr && !st_q.comm_req[5]
      |=> !st_q.comm_req[5])
    else $error("receive flag set with empty FIFO");
  a_unknown_cmd: assert property (events.cmd_host_write
      && !known_cmd_mask[events.cmd_host_code]
      |=> cmd_force_idle && st_q.comm_req[4])
    else $error("unknown command not returned to idle");
  a_host_idle: assert property (events.cmd_host_write
      && events.cmd_host_code == `CIRQ_CMD_IDLE && !events.cmd_self_done && !reg_wr
      |=> st_q.comm_req[4] == $past(st_q.comm_req[4]))
    else $error("host idle changed idle flag");
  a_err_flag: assert property ((|events.error_status) |=> st_q.comm_req[1])
    else $error("error flag missed");
  a_sig_edge: assert property (st_q.seen && $changed(events.secure_link_input)
      |=> st_q.div_req[4])
    else $error("secure input edge missed");
  a_field_off: assert property (st_q.seen && $fell(events.external_field)
      |=> st_q.div_req[0])
    else $error("field off missed");
  a_pin_pushpull: assert property (st_q.div_en[7] |-> irq_pin_oe
      && irq_pin_o == (st_q.irq_status ^ st_q.comm_en[7]))
    else $error("push-pull pin wrong");
  a_pin_opendrain: assert property (!st_q.div_en[7] |-> !irq_pin_o
      && irq_pin_oe == !(st_q.irq_status ^ st_q.comm_en[7]))
    else $error("open-drain pin wrong");
  a_status_any: assert property (st_q.irq_status ==
      ((|(st_q.comm_req & st_q.comm_en[6:0])) || (|(st_q.div_req & st_q.div_en[4:0]))))
    else $error("combined status wrong");

  c_clear_write: cover property (wr_comm_req && !reg_wdata[7]);
  c_mode_found: cover property (mode_detector_run && events.mode_found);
  c_pin_pull_low: cover property (!st_q.div_en[7] && irq_pin_oe);
  c_set_beats_clear: cover property (wr_div_req && !reg_wdata[7] && (|div_set));

endmodule // cirq_unit

// >>> cirq_host_model.sv
// Host-side model of the interrupt wire: board pull-up and resolved level.
`timescale 1ns/1ps

module cirq_host_model (
  // Pin as driven by the unit.
  input  wire logic irq_pin_o,
  input  wire logic irq_pin_oe,
  // Wire level as the host's port pin sees it.
  output logic      irq_line
);
  // The pull-up holds the wire high whenever the unit lets go, so an
  // open-drain pin that is released never reads as a stale value.
  assign irq_line = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule // cirq_host_model

// >>> contactless_irq_request_unit_tb.sv
// Self-checking bench for the contactless interrupt request unit.
`timescale 1ns/1ps
`include "cirq_map.svh"

module contactless_irq_request_unit_tb import cirq_pkg::*;;
  logic         mclk;               // System clock.
  logic         rstn;               // Reset, active low.
  logic [5:0]   reg_addr;           // Register address.
  logic [7:0]   reg_wdata;          // Write data.
  logic         reg_wr;             // Write strobe.
  logic         reg_rd;             // Read strobe.
  logic [7:0]   reg_rdata;          // Read data.
  cirq_events_t ev;                 // Events driven to the unit.
  cirq_events_t quiet;              // Events at rest.
  cirq_events_t e;                  // Scratch event set.
  logic         cmd_force_idle;     // Command return pulse.
  logic         mode_detector_run;  // Detector hunting.
  logic         irq_pin_o;          // Pin value.
  logic         irq_pin_oe;         // Pin enable.
  logic         irq_line;           // Resolved wire.
  logic [7:0]   rd;                 // Last read value.
  logic         fi;                 // Force-idle seen after an event.
  logic         lvl;                // Expected pin level.
  logic [3:0]   k;                  // Row kind; f means a register write.
  logic [5:0]   a;                  // Row address.
  logic [7:0]   w;                  // Row write data.
  logic [7:0]   x;                  // Row expected read.
  logic [25:0]  rows [0:24];        // Ordinary cases.
  int           failures;           // Mismatches.
  int           n_checks;           // Comparisons.

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  cirq_unit i_dut (
    .mclk              (mclk),
    .rstn              (rstn),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .events            (ev),
    .cmd_force_idle    (cmd_force_idle),
    .mode_detector_run (mode_detector_run),
    .irq_pin_o         (irq_pin_o),
    .irq_pin_oe        (irq_pin_oe)
  );

  cirq_host_model i_host (
    .irq_pin_o  (irq_pin_o),
    .irq_pin_oe (irq_pin_oe),
    .irq_line   (irq_line)
  );

  // Compares one byte and reports a mismatch at once.
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle register write; returns at the edge that takes it.
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read; the data stand only in the following cycle.
  task automatic rdr(input logic [5:0] ad);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // Holds an event set for one cycle, then returns to rest.
  task automatic fire(input cirq_events_t es);
    @(posedge mclk);
    ev <= es;
    @(posedge mclk);
    ev <= quiet;
    #1 fi = cmd_force_idle;
  endtask

  // Builds the event set of one table row.
  function automatic cirq_events_t ev_of(input logic [3:0] kind);
    cirq_events_t r;
    r = quiet;
    case (kind)
      4'h0: r.tx_last_bit_sent = 1'b1;
      4'h1: r.rx_end_valid = 1'b1;
      4'h2: r.cmd_self_done = 1'b1;
      4'h3: r.cmd_host_write = 1'b1;
      4'h4: begin
        r.cmd_host_write = 1'b1;
        r.cmd_host_code  = 4'h4;
      end
      4'h5: r.fifo_high_level = 1'b1;
      4'h6: r.fifo_low_level = 1'b1;
      4'h7: r.error_status = 8'h20;
      4'h8: r.countdown_current_value = 16'h0000;
      4'h9: r.secure_link_input = 1'b1;
      4'ha: r.checksum_all_done = 1'b1;
      4'hb: begin
        r.checksum_all_done   = 1'b1;
        r.checksum_cmd_active = 1'b1;
      end
      4'hc: r.external_field = 1'b1;
      default: r = quiet;
    endcase
    return r;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks made: %0d, failures: %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs well under a thousand cycles.
  initial begin
    #200000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence.
  initial begin
    // The timer rests at a nonzero value so that reaching zero is an edge.
    quiet = '0;
    quiet.countdown_current_value = 16'h0003;
    ev = quiet;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    failures = 0;
    n_checks = 0;
    rstn = 1'b0;
    rows = '{
      {4'hf, 6'h04, 8'h14, 8'h00}, {4'hf, 6'h04, 8'hff, 8'h7f},
      {4'hf, 6'h04, 8'haa, 8'h2a}, {4'hf, 6'h04, 8'h7f, 8'h00},
      {4'hf, 6'h05, 8'h9f, 8'h1f}, {4'hf, 6'h05, 8'h8a, 8'h0a},
      {4'hf, 6'h05, 8'h1f, 8'h00}, {4'hf, 6'h03, 8'hff, 8'h9f},
      {4'hf, 6'h03, 8'h00, 8'h00}, {4'hf, 6'h3f, 8'hff, 8'h00},
      {4'hf, 6'h07, 8'hff, 8'h00}, {4'hf, 6'h02, 8'h80, 8'h80},
      {4'h0, 6'h04, 8'h00, 8'h40}, {4'h1, 6'h04, 8'h00, 8'h20},
      {4'h2, 6'h04, 8'h00, 8'h10}, {4'h3, 6'h04, 8'h00, 8'h00},
      {4'h4, 6'h04, 8'h00, 8'h10}, {4'h5, 6'h04, 8'h00, 8'h08},
      {4'h6, 6'h04, 8'h00, 8'h04}, {4'h7, 6'h04, 8'h00, 8'h02},
      {4'h8, 6'h04, 8'h00, 8'h01}, {4'h9, 6'h05, 8'h00, 8'h10},
      {4'ha, 6'h05, 8'h00, 8'h00}, {4'hb, 6'h05, 8'h00, 8'h04},
      {4'hc, 6'h05, 8'h00, 8'h03}
    };
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    // Each row is a write or an event, a read-back, then a full flag clear.
    foreach (rows[i]) begin
      {k, a, w, x} = rows[i];
      if (k == 4'hf) begin
        wr(a, w);
      end else begin
        fire(ev_of(k));
        check({7'h0, fi}, {7'h0, k == 4'h4}, "force idle");
      end
      rdr(a);
      check(rd, x, "row read");
      wr(6'h04, 8'h7f);
      wr(6'h05, 8'h1f);
    end
    $display("Table test done");
    // Reading twice leaves a flag in place.
    wr(6'h04, 8'hc0);
    rdr(6'h04);
    check(rd, 8'h40, "first read");
    rdr(6'h04);
    check(rd, 8'h40, "second read");
    wr(6'h04, 8'h7f);
    // With ignore-empty set, an end of reception with an empty FIFO is dropped.
    wr(6'h0c, 8'h01);
    rdr(6'h0c);
    check(rd, 8'h01, "ignore-empty readback");
    e = ev_of(4'h1);
    fire(e);
    rdr(6'h04);
    check(rd, 8'h00, "rx empty");
    e.rx_fifo_has_data = 1'b1;
    fire(e);
    rdr(6'h04);
    check(rd, 8'h20, "rx with data");
    wr(6'h04, 8'h7f);
    $display("Receive test done");
    // A falling edge alone on the secure-link input also raises its flag.
    quiet.secure_link_input = 1'b1;
    fire(quiet);
    wr(6'h05, 8'h1f);
    quiet.secure_link_input = 1'b0;
    fire(quiet);
    rdr(6'h05);
    check(rd, 8'h10, "falling edge");
    wr(6'h05, 8'h1f);
    // Mode detection counts only while the detector hunts.
    e = quiet;
    e.mode_found = 1'b1;
    fire(e);
    rdr(6'h05);
    check(rd, 8'h00, "mode while off");
    quiet.auto_anticollision_command = 1'b1;
    fire(quiet);
    repeat (2) @(posedge mclk);
    #1 check({7'h0, mode_detector_run}, 8'h01, "detector start");
    e.auto_anticollision_command = 1'b1;
    fire(e);
    rdr(6'h05);
    check(rd, 8'h08, "mode found");
    check({7'h0, mode_detector_run}, 8'h00, "detector stop");
    wr(6'h05, 8'h1f);
    fire(e);
    rdr(6'h05);
    check(rd, 8'h00, "mode after stop");
    e = quiet;
    e.field_reset = 1'b1;
    fire(e);
    repeat (2) @(posedge mclk);
    #1 check({7'h0, mode_detector_run}, 8'h01, "detector restart");
    quiet.auto_anticollision_command = 1'b0;
    fire(quiet);
    repeat (2) @(posedge mclk);
    #1 check({7'h0, mode_detector_run}, 8'h00, "detector off");
    $display("Detector test done");
    // Each divided enable passes only its own flag, push-pull, no inversion.
    wr(6'h02, 8'h00);
    wr(6'h05, 8'h9f);
    for (int i = 0; i < 5; i++) begin
      wr(6'h03, 8'h80 | (8'h01 << i));
      #1 check({7'h0, irq_line}, 8'h01, "enabled flag");
      wr(6'h05, 8'h01 << i);
      #1 check({7'h0, irq_line}, 8'h00, "other flags masked");
      wr(6'h05, 8'h80 | (8'h01 << i));
    end
    wr(6'h05, 8'h1f);
    // All four pairs of inversion and drive kind with one enabled flag.
    wr(6'h04, 8'hc0);
    for (int n = 0; n < 4; n++) begin
      wr(6'h02, {n[1], 7'h40});
      wr(6'h03, {n[0], 7'h00});
      lvl = ~n[1];
      #1 check({6'h0, irq_pin_oe, irq_line}, {6'h0, n[0] | ~lvl, lvl}, "pin drive");
      if (!n[0]) check({7'h0, irq_pin_o}, 8'h00, "open drain high");
    end
    // The enabled transmit flag shows as the combined request in the status byte.
    rdr(6'h07);
    check(rd, 8'h10, "status irq");
    // Read data stand for one cycle only and then fall back to zero.
    @(posedge mclk);
    #1 check(reg_rdata, 8'h00, "read data one cycle");
    $display("Pin test done");
    // A second reset in mid-run releases the pin and restores the registers.
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (8) @(posedge mclk);
    check({4'h0, irq_pin_o, irq_pin_oe, cmd_force_idle, mode_detector_run}, 8'h00, "in reset");
    check(reg_rdata, 8'h00, "read data in reset");
    check({7'h0, irq_line}, 8'h01, "line in reset");
    rstn <= 1'b1;
    rdr(6'h02);
    check(rd, 8'h80, "comm enable reset");
    rdr(6'h03);
    check(rd, 8'h00, "divided enable reset");
    rdr(6'h04);
    check(rd, 8'h14, "comm flags reset");
    rdr(6'h05);
    check(rd, 8'h00, "divided flags reset");
    rdr(6'h0c);
    check(rd, 8'h00, "receive config reset");
    $display("Reset test done");
    report_and_stop();
  end
endmodule // contactless_irq_request_unit_tb
